// [rtw_top.sv]
// Clock and alarm register windows with pointer walk and write lock
//
// Notes on behaviour
// - The time pointer sits at bits 9:8 of the clock config register and picks the time pair.
// - A write to the time high byte steps the time pointer down, stopping at zero.
// - Time pointer 0 is min/sec, 1 weekday/hours, 2 month/day, 3 year in the low byte only.
// - The alarm pointer sits at bits 9:8 of the alarm config register and picks the alarm pair.
// - A write to the alarm high byte steps the alarm pointer down, stopping at zero.
// - Alarm pointer 0 is min/sec, 1 weekday/hours, 2 month/day, 3 maps nothing.
// - Reading either alarm window byte steps the alarm pointer down, stopping at zero.
// - Reading either time window byte steps the time pointer down, stopping at zero.
// - Writing a window low byte leaves its pointer alone.
// - Time bytes change only while the time write enable bit 13 is set.
// - The enable bit can be set only in the one cycle after the 55h then AAh key writes.
`timescale 1ns/1ps
`default_nettype none
module rtw_top
    import rtw_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    output logic                   time_write_enable
);

    logic [1:0]        tptr;
    logic [1:0]        aptr;
    logic [7:0]        cal;
    logic [7:0]        alm_low;
    logic              window_open;
    logic [7:0]        tbyte [TIME_ENTRIES];
    logic [7:0]        abyte [ALM_ENTRIES];
    logic [DATA_W-1:0] next_rdata;

    // Address decode
    wire wr_clk_cfg = wr && (addr == OFS_CLK_CFG);
    wire wr_alm_cfg = wr && (addr == OFS_ALM_CFG);
    wire wr_time_lo = wr && (addr == OFS_TIME_LO);
    wire wr_time_hi = wr && (addr == OFS_TIME_HI);
    wire wr_alm_lo  = wr && (addr == OFS_ALM_LO);
    wire wr_alm_hi  = wr && (addr == OFS_ALM_HI);
    wire wr_key     = wr && (addr == OFS_KEY);
    wire rd_time    = rd && ((addr == OFS_TIME_LO) || (addr == OFS_TIME_HI));
    wire rd_alm     = rd && ((addr == OFS_ALM_LO) || (addr == OFS_ALM_HI));

    // Pointer steps: high-byte writes and any byte read
    wire tptr_dec = wr_time_hi || rd_time;
    wire aptr_dec = wr_alm_hi || rd_alm;

    // Time pointer in the clock config register
    rtw_ptr u_time_ptr (
        .clk      (clk),
        .arst_n   (arst_n),
        .load     (wr_clk_cfg),
        .load_val (wdata[PTR_MSB:PTR_LSB]),
        .dec      (tptr_dec),
        .ptr      (tptr)
    );

    // Alarm pointer in the alarm config register
    rtw_ptr u_alarm_ptr (
        .clk      (clk),
        .arst_n   (arst_n),
        .load     (wr_alm_cfg),
        .load_val (wdata[PTR_MSB:PTR_LSB]),
        .dec      (aptr_dec),
        .ptr      (aptr)
    );

    // Key sequence; every non-key access counts as a break
    rtw_unlock u_unlock (
        .clk          (clk),
        .arst_n       (arst_n),
        .key_wr       (wr_key),
        .key_byte     (wdata[LOW_MSB:0]),
        .other_access ((wr && !wr_key) || rd),
        .window_open  (window_open)
    );

    // Clearing is always allowed; setting needs the open window or an already set bit
    wire next_wren = wdata[WREN_BIT] && (time_write_enable || window_open);

    // Configuration storage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            time_write_enable <= 1'b0;
            cal               <= BYTE_ZERO;
            alm_low           <= BYTE_ZERO;
        end else begin
            if (wr_clk_cfg) begin
                time_write_enable <= next_wren;
                cal               <= wdata[LOW_MSB:0];
            end
            if (wr_alm_cfg) begin
                alm_low <= wdata[LOW_MSB:0];
            end
        end
    end

    // Entry selection: {pointer, high byte}; index 7 maps nothing
    wire [IDX_W-1:0] time_idx = {tptr, (addr == OFS_TIME_HI)};
    wire [IDX_W-1:0] alm_idx  = {aptr, (addr == OFS_ALM_HI)};
    wire             time_we  = (wr_time_lo || wr_time_hi) && time_write_enable;
    wire             alm_we   = wr_alm_lo || wr_alm_hi;

    // Time and alarm byte storage, one flop byte per entry
    genvar gi;
    generate
        for (gi = 0; gi < TIME_ENTRIES; gi++) begin : g_time
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    tbyte[gi] <= BYTE_ZERO;
                end else if (time_we && (time_idx == IDX_W'(gi))) begin
                    tbyte[gi] <= wdata[LOW_MSB:0];
                end
            end
        end
        for (gi = 0; gi < ALM_ENTRIES; gi++) begin : g_alarm
            // Pointer 3 lands on indices 6 and 7, neither exists here
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    abyte[gi] <= BYTE_ZERO;
                end else if (alm_we && (alm_idx == IDX_W'(gi))) begin
                    abyte[gi] <= wdata[LOW_MSB:0];
                end
            end
        end
    endgenerate

    // Window read bytes; unmapped slots read as zero
    wire [7:0] time_rd = (time_idx < IDX_W'(TIME_ENTRIES)) ? tbyte[time_idx] : BYTE_ZERO;
    wire [7:0] alm_rd  = (alm_idx < IDX_W'(ALM_ENTRIES)) ? abyte[alm_idx] : BYTE_ZERO;

    // Readback words of the two config registers
    wire [DATA_W-1:0] clk_cfg_word = {2'h0, time_write_enable, 3'h0, tptr, cal};
    wire [DATA_W-1:0] alm_cfg_word = {6'h00, aptr, alm_low};

    // Read mux; values sampled before the pointer steps
    assign next_rdata = (addr == OFS_CLK_CFG) ? clk_cfg_word :
                        (addr == OFS_ALM_CFG) ? alm_cfg_word :
                        ((addr == OFS_TIME_LO) || (addr == OFS_TIME_HI)) ? {BYTE_ZERO, time_rd} :
                        ((addr == OFS_ALM_LO) || (addr == OFS_ALM_HI)) ? {BYTE_ZERO, alm_rd} :
                        WORD_ZERO;

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= WORD_ZERO;
        end else begin
            rdata <= rd ? next_rdata : WORD_ZERO;
        end
    end

    // Checks on the behaviour above
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    wren_set_a: assert property ($rose(time_write_enable) |->
        $past(window_open) && $past(wr_clk_cfg))
        else $error("write enable set outside the unlock window");

    wren_lock_a: assert property (wr_clk_cfg && wdata[WREN_BIT] && !window_open
        && !time_write_enable |=> !time_write_enable)
        else $error("write enable set without key sequence");

    tptr_step_a: assert property (tptr_dec && (tptr != PTR_ZERO) |=>
        tptr == ($past(tptr) - 2'h1))
        else $error("time pointer did not step down");

    tptr_floor_a: assert property (rd_time && (tptr == PTR_ZERO) |=>
        tptr == PTR_ZERO)
        else $error("time pointer left zero on read");

    time_lo_wr_a: assert property (wr_time_lo |=> $stable(tptr))
        else $error("time low byte write moved pointer");

    aptr_step_a: assert property (aptr_dec && (aptr != PTR_ZERO) |=>
        aptr == ($past(aptr) - 2'h1))
        else $error("alarm pointer did not step down");

    alm_lo_wr_a: assert property (wr_alm_lo |=> $stable(aptr))
        else $error("alarm low byte write moved pointer");

    time_lock_a: assert property (wr_time_lo && !time_write_enable && (tptr == PTR_ZERO)
        |=> $stable(tbyte[0]))
        else $error("locked time write changed seconds");

    year_high_a: assert property (rd && (addr == OFS_TIME_HI) && (tptr == PTR_LAST)
        |=> rdata == WORD_ZERO)
        else $error("year slot high byte not zero");

    alarm_none_a: assert property (rd && (addr == OFS_ALM_LO) && (aptr == PTR_LAST)
        |=> rdata == WORD_ZERO)
        else $error("alarm slot 3 not empty");

    cfg_ptr_rd_a: assert property (rd && (addr == OFS_CLK_CFG) |=>
        rdata[PTR_MSB:PTR_LSB] == $past(tptr))
        else $error("time pointer field misread");

    alm_ptr_rd_a: assert property (rd && (addr == OFS_ALM_CFG) |=>
        rdata[PTR_MSB:PTR_LSB] == $past(aptr))
        else $error("alarm pointer field misread");

    // Pointer loads and floors
    tptr_load_a: assert property (wr_clk_cfg |=>
        tptr == $past(wdata[PTR_MSB:PTR_LSB]))
        else $error("time pointer load lost");

    aptr_load_a: assert property (wr_alm_cfg |=>
        aptr == $past(wdata[PTR_MSB:PTR_LSB]))
        else $error("alarm pointer load lost");

    tptr_hi_floor_a: assert property (wr_time_hi && (tptr == PTR_ZERO) |=>
        tptr == PTR_ZERO)
        else $error("time pointer left zero on write");

    aptr_hi_floor_a: assert property (wr_alm_hi && (aptr == PTR_ZERO) |=>
        aptr == PTR_ZERO)
        else $error("alarm pointer left zero on write");

    aptr_floor_a: assert property (rd_alm && (aptr == PTR_ZERO) |=>
        aptr == PTR_ZERO)
        else $error("alarm pointer left zero on read");

    // A pointer moves only on its own accesses
    tptr_quiet_a: assert property (!tptr_dec && !wr_clk_cfg |=>
        $stable(tptr))
        else $error("time pointer moved without access");

    aptr_quiet_a: assert property (!aptr_dec && !wr_alm_cfg |=>
        $stable(aptr))
        else $error("alarm pointer moved without access");

    // Enable bit and unlock window
    wren_clear_a: assert property (wr_clk_cfg && !wdata[WREN_BIT] |=>
        !time_write_enable)
        else $error("write enable did not clear");

    wren_hold_a: assert property (!wr_clk_cfg |=>
        $stable(time_write_enable))
        else $error("write enable changed without config write");

    window_once_a: assert property (window_open |=>
        !window_open)
        else $error("unlock window longer than one cycle");

    window_key_a: assert property (window_open |->
        $past(wr_key) && ($past(wdata[LOW_MSB:0]) == KEY_SECOND))
        else $error("unlock window opened without second key");

    // Time byte storage under the lock
    time_write_a: assert property (wr_time_lo && time_write_enable && (tptr == PTR_ZERO) |=>
        tbyte[0] == $past(wdata[LOW_MSB:0]))
        else $error("enabled seconds write lost");

    time_lock_hi_a: assert property (wr_time_hi && !time_write_enable && (tptr == PTR_ZERO) |=>
        $stable(tbyte[1]))
        else $error("locked time write changed minutes");

    cfg_wren_rd_a: assert property (rd && (addr == OFS_CLK_CFG) |=>
        rdata[WREN_BIT] == $past(time_write_enable))
        else $error("write enable field misread");

    // Read data shape
    time_upper_a: assert property (rd_time |=>
        rdata[DATA_W-1:LOW_MSB+1] == BYTE_ZERO)
        else $error("time window upper byte not zero");

    alm_upper_a: assert property (rd_alm |=>
        rdata[DATA_W-1:LOW_MSB+1] == BYTE_ZERO)
        else $error("alarm window upper byte not zero");

    minutes_rd_a: assert property (rd && (addr == OFS_TIME_HI) && (tptr == PTR_ZERO) |=>
        rdata[LOW_MSB:0] == $past(tbyte[1]))
        else $error("minutes not shown at pointer zero");

    alm_sec_rd_a: assert property (rd && (addr == OFS_ALM_LO) && (aptr == PTR_ZERO) |=>
        rdata[LOW_MSB:0] == $past(abyte[0]))
        else $error("alarm seconds not shown at pointer zero");

    alm_hi_none_a: assert property (rd && (addr == OFS_ALM_HI) && (aptr == PTR_LAST) |=>
        rdata == WORD_ZERO)
        else $error("alarm slot 3 high byte not empty");

    key_rd_zero_a: assert property (rd && (addr == OFS_KEY) |=>
        rdata == WORD_ZERO)
        else $error("key register not read as zero");

    unmapped_rd_a: assert property (rd && (addr > OFS_KEY) |=>
        rdata == WORD_ZERO)
        else $error("unmapped offset not read as zero");

    rd_idle_a: assert property (!rd |=>
        rdata == WORD_ZERO)
        else $error("read data outside its answer cycle");

endmodule
`default_nettype wire

// [rtw_pkg.sv]
// Constants, offsets and types shared by the clock register window files
package rtw_pkg;

    // Register bus shape
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;

    // Register offsets on the plain register port
    localparam logic [ADDR_W-1:0] OFS_CLK_CFG = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_ALM_CFG = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_TIME_LO = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_TIME_HI = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_ALM_LO  = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_ALM_HI  = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_KEY     = 3'h6;

    // Field positions in the two configuration registers
    localparam int PTR_LSB  = 8;
    localparam int PTR_MSB  = 9;
    localparam int WREN_BIT = 13;
    localparam int LOW_MSB  = 7;

    // Pointer values
    localparam logic [1:0] PTR_ZERO = 2'h0;
    localparam logic [1:0] PTR_LAST = 2'h3;

    // Unlock key bytes
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Storage: entry index is {pointer, high byte}
    localparam int IDX_W        = 3;
    localparam int TIME_ENTRIES = 7;
    localparam int ALM_ENTRIES  = 6;
    localparam logic [7:0]        BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;

    // Unlock sequence states
    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_HALF = 2'b01,
        KEY_OPEN = 2'b10
    } rtw_key_state_t;

endpackage

// [rtw_ptr.sv]
// Two-bit window pointer that loads from software and counts down to zero
`timescale 1ns/1ps
`default_nettype none
module rtw_ptr
    import rtw_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       load,
    input  wire logic [1:0] load_val,
    input  wire logic       dec,
    output var  logic [1:0] ptr
);

    logic [1:0] next_ptr;

    // Load wins; decrement saturates at zero
    assign next_ptr = load ? load_val :
                      (dec && (ptr != PTR_ZERO)) ? (ptr - 2'h1) : ptr;

    // Pointer register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr <= PTR_ZERO;
        end else begin
            ptr <= next_ptr;
        end
    end

endmodule
`default_nettype wire

// [rtw_unlock.sv]
// Key sequence detector that opens a one-cycle write-enable window
`timescale 1ns/1ps
`default_nettype none
module rtw_unlock
    import rtw_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       key_wr,
    input  wire logic [7:0] key_byte,
    input  wire logic       other_access,
    output logic            window_open
);

    rtw_key_state_t state;
    rtw_key_state_t next_state;

    wire first_key  = key_wr && (key_byte == KEY_FIRST);
    wire second_key = key_wr && (key_byte == KEY_SECOND);

    // Any stray access breaks the sequence; idle cycles do not
    always_comb begin
        next_state = state;
        unique case (state)
            KEY_IDLE: begin
                if (first_key) begin
                    next_state = KEY_HALF;
                end
            end
            KEY_HALF: begin
                if (second_key) begin
                    next_state = KEY_OPEN;
                end else if (first_key) begin
                    next_state = KEY_HALF;
                end else if (key_wr || other_access) begin
                    next_state = KEY_IDLE;
                end
            end
            KEY_OPEN: begin
                // Window lasts one cycle only
                next_state = first_key ? KEY_HALF : KEY_IDLE;
            end
            default: begin
                next_state = KEY_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= KEY_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign window_open = (state == KEY_OPEN);

endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the clock and alarm register windows
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rtw_pkg::*;
;
    logic              clk;
    logic              arst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              time_write_enable;
    int                n_fail;
    int                compares;

    rtw_top i_dut (
        .clk               (clk),
        .arst_n            (arst_n),
        .addr              (addr),
        .wdata             (wdata),
        .wr                (wr),
        .rd                (rd),
        .rdata             (rdata),
        .time_write_enable (time_write_enable)
    );

    // 20 MHz clock
    always #25 clk = ~clk;

    task automatic test_done();
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle; every signal set once per edge, so calls may run back to back
    task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= w;
        rd    <= r;
        addr  <= a;
        wdata <= d;
    endtask

    task automatic idle();
        bus(1'b0, 1'b0, 3'h0, 16'h0000);
    endtask

    task automatic wrr(input logic [2:0] a, input logic [15:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    // Read data is only valid in the cycle after the strobe, so sample just past that edge
    task automatic rdc(input string what, input logic [2:0] a, input logic [15:0] exp);
        bus(1'b0, 1'b1, a, 16'h0000);
        idle();
        #1;
        chk(what, exp, rdata);
    endtask

    task automatic wren_chk(input logic exp);
        idle();
        #1;
        chk("write enable", {15'h0000, exp}, {15'h0000, time_write_enable});
    endtask

    task automatic unlock();
        wrr(OFS_KEY, 16'h0055);
        wrr(OFS_KEY, 16'h00AA);
    endtask

    // Reset values, also after a reset in mid-run
    task automatic t_reset();
        rdc("clock config", OFS_CLK_CFG, 16'h0000);
        rdc("alarm config", OFS_ALM_CFG, 16'h0000);
        rdc("unmapped", 3'h7, 16'h0000);
        rdc("key reads zero", OFS_KEY, 16'h0000);
        wren_chk(1'b0);
    endtask

    // Broken or late key sequences must not let the enable bit set
    task automatic t_lock();
        wrr(OFS_KEY, 16'h0055);
        rdc("time low", OFS_TIME_LO, 16'h0000);
        wrr(OFS_KEY, 16'h00AA);
        wrr(OFS_CLK_CFG, 16'h2000);
        wren_chk(1'b0);
        unlock();
        idle();
        wrr(OFS_CLK_CFG, 16'h2000);
        wren_chk(1'b0);
        wrr(OFS_CLK_CFG, 16'h2000);
        wren_chk(1'b0);
        // Locked: time byte writes are dropped
        wrr(OFS_TIME_LO, 16'h0011);
        rdc("locked time low", OFS_TIME_LO, 16'h0000);
        wrr(OFS_TIME_HI, 16'h0044);
        rdc("locked minutes", OFS_TIME_HI, 16'h0000);
    endtask

    // Unlock (with a restarted first key), then walk the time window down from 3
    task automatic t_time();
        wrr(OFS_KEY, 16'h0055);
        unlock();
        wrr(OFS_CLK_CFG, 16'h2300);
        wren_chk(1'b1);
        rdc("config after unlock", OFS_CLK_CFG, 16'h2300);
        wrr(OFS_TIME_LO, 16'h0036);
        wrr(OFS_TIME_HI, 16'h0077);
        wrr(OFS_TIME_LO, 16'h0014);
        rdc("ptr after low write", OFS_CLK_CFG, 16'h2200);
        wrr(OFS_TIME_HI, 16'h0005);
        wrr(OFS_TIME_LO, 16'h0011);
        wrr(OFS_TIME_HI, 16'h0003);
        wrr(OFS_TIME_LO, 16'h0022);
        wrr(OFS_TIME_HI, 16'h0033);
        wrr(OFS_TIME_HI, 16'h0033);
        rdc("ptr held at zero", OFS_CLK_CFG, 16'h2000);
        // Read back from 3; each read steps the pointer down, stopping at zero
        wrr(OFS_CLK_CFG, 16'h2300);
        rdc("time hi ptr 3", OFS_TIME_HI, 16'h0000);
        rdc("day", OFS_TIME_LO, 16'h0014);
        rdc("weekday", OFS_TIME_HI, 16'h0003);
        rdc("seconds", OFS_TIME_LO, 16'h0022);
        rdc("minutes", OFS_TIME_HI, 16'h0033);
        wrr(OFS_CLK_CFG, 16'h2300);
        rdc("year", OFS_TIME_LO, 16'h0036);
        rdc("month", OFS_TIME_HI, 16'h0005);
        rdc("hours", OFS_TIME_LO, 16'h0011);
        wrr(OFS_CLK_CFG, 16'h0000);
        wren_chk(1'b0);
        wrr(OFS_TIME_LO, 16'h0099);
        rdc("seconds kept", OFS_TIME_LO, 16'h0022);
    endtask

    // Alarm window walk; pointer 3 maps nothing
    task automatic t_alarm();
        wrr(OFS_ALM_CFG, 16'h0300);
        wrr(OFS_ALM_LO, 16'h0066);
        wrr(OFS_ALM_HI, 16'h0066);
        rdc("alarm ptr 2", OFS_ALM_CFG, 16'h0200);
        wrr(OFS_ALM_LO, 16'h0009);
        rdc("alarm ptr low write", OFS_ALM_CFG, 16'h0200);
        wrr(OFS_ALM_HI, 16'h000C);
        wrr(OFS_ALM_LO, 16'h0007);
        wrr(OFS_ALM_HI, 16'h0002);
        wrr(OFS_ALM_LO, 16'h0045);
        wrr(OFS_ALM_HI, 16'h0030);
        rdc("alarm ptr zero", OFS_ALM_CFG, 16'h0000);
        wrr(OFS_ALM_CFG, 16'h0300);
        rdc("alarm lo ptr 3", OFS_ALM_LO, 16'h0000);
        rdc("alarm day", OFS_ALM_LO, 16'h0009);
        rdc("alarm weekday", OFS_ALM_HI, 16'h0002);
        rdc("alarm minutes", OFS_ALM_HI, 16'h0030);
        rdc("alarm seconds", OFS_ALM_LO, 16'h0045);
        wrr(OFS_ALM_CFG, 16'h0200);
        rdc("alarm month", OFS_ALM_HI, 16'h000C);
        rdc("alarm hours", OFS_ALM_LO, 16'h0007);
        // Unused config bits read zero, stored bytes come back
        wrr(OFS_ALM_CFG, 16'hFFA5);
        rdc("alarm config bits", OFS_ALM_CFG, 16'h03A5);
        rdc("alarm hi ptr 3", OFS_ALM_HI, 16'h0000);
        wrr(OFS_CLK_CFG, 16'hDF5A);
        rdc("clock config bits", OFS_CLK_CFG, 16'h035A);
    endtask

    // Reset in mid-run with the enable set and the pointer moved
    task automatic t_midrst();
        unlock();
        wrr(OFS_CLK_CFG, 16'h2100);
        wren_chk(1'b1);
        @(negedge clk);
        arst_n = 1'b0;
        @(negedge clk);
        arst_n = 1'b1;
        t_reset();
    endtask

    // Watchdog: the run is short, so a hang means something is stuck
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        test_done();
    end

    initial begin
        clk      = 1'b0;
        arst_n   = 1'b0;
        addr     = 3'h0;
        wdata    = 16'h0000;
        wr       = 1'b0;
        rd       = 1'b0;
        n_fail   = 0;
        compares = 0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_lock();
        t_time();
        t_alarm();
        t_midrst();
        test_done();
    end
endmodule
`default_nettype wire
